// ---- logic/info_section_parser.sv ----
// parser end: decodes one information-table section per frame
// assumes: frames from section_source on the same clock; descriptor bodies skipped
`timescale 1ns/1ps
module info_section_parser
  import info_section_pkg::*;
(
  input  wire logic        clk_i,          // 50 MHz clock
  input  wire logic        resetn_i,       // async reset, active low
  section_link_if.sink     link,           // from the source
  output logic             hdr_valid_o,    // header decoded pulse
  output logic [3:0]       ver_major_o,    // protocol major
  output logic [3:0]       ver_minor_o,    // protocol minor
  output logic [7:0]       subnet_o,       // subnet identity
  output logic [15:0]      service_o,      // service identity
  output logic [31:0]      span_start_o,   // span start seconds
  output logic [10:0]      span_len_o,     // span length minutes
  output logic [4:0]       version_o,      // instance version
  output logic             new_inst_o,     // header starts a changed instance
  output logic             item_valid_o,   // item decoded pulse
  output logic [31:0]      linkage_o,      // item linkage
  output logic [7:0]       item_flags_o,   // item flag byte
  output logic [19:0]      pb_len_o,       // playback length
  output logic [19:0]      pb_delay_o,     // playback delay
  output logic [31:0]      expiry_o,       // expiration
  output logic [39:0]      size_o,         // content size
  output logic             warn_o,         // item or header warning pulse
  output logic             done_o,         // section accepted pulse
  output logic             complete_o,     // instance complete level
  output logic             error_o,        // section discarded pulse
  output err_code_t        err_code_o      // reason of last error
);
  typedef enum logic [13:0] {
    S_IDLE  = 14'h0001, S_HDR   = 14'h0002, S_LINK  = 14'h0004, S_FLAG1 = 14'h0008,
    S_FLAG2 = 14'h0010, S_OPT   = 14'h0020, S_NLEN  = 14'h0040, S_NAME  = 14'h0080,
    S_DCNT  = 14'h0100, S_DTAG  = 14'h0200, S_DLEN  = 14'h0400, S_DBODY = 14'h0800,
    S_TAIL  = 14'h1000, S_DROP  = 14'h2000
  } state_t;

  // all registered state apart from the walker state
  typedef struct packed {
    logic [3:0]   idx;                    // header byte index
    logic [11:0]  remain;                 // section bytes still owed
    logic [39:0]  acc;                    // field accumulator
    logic [7:0]   items, cnt, dlen;       // items left, field or descriptor count, bytes left
    logic [2:0]   opt;                    // optional field in hand, 4 = none left
    logic         outer, k_ok, m_ok;      // section-level loop, key held, master held
    logic [7:0]   secno, lastno, subnet;  // section numbers, subnet identity
    logic [255:0] seen;                   // sections of the instance seen
    logic [15:0]  k_svc, k_ext, m_svc, service;
    logic [31:0]  k_start, m_lk, span_start, linkage, expiry;
    logic [10:0]  k_len, span_len;
    logic [4:0]   k_ver, version;
    logic [3:0]   major, minor;
    logic [7:0]   flags;
    logic [19:0]  pb_len, pb_delay;
    logic [39:0]  size;
    logic         hdr_valid, new_inst, item_valid, warn, done, complete, error;
    err_code_t    err_code;
  } regs_t;

  state_t     st, next_st;
  regs_t      r, next_r;
  logic       take;      // byte accepted this cycle
  logic [7:0] b;         // byte on the link
  logic       key_hit;   // header repeats the held instance key
  logic       fail;      // mandatory field mismatch on this byte
  err_code_t  code;      // reason that goes with fail
  logic       desc_end;  // a descriptor ends on this byte
  logic       loop_end;  // a descriptor loop ends on this byte

  // next byte of a big-endian field
  function automatic logic [39:0] shift_in(input logic [39:0] acc, input logic [7:0] b);
    shift_in = {acc[31:0], b};
  endfunction : shift_in

  // first optional field at or after from whose include flag is set, 4 if none
  function automatic logic [2:0] opt_from(input logic [7:0] f, input logic [2:0] from);
    opt_from = 3'h4;
    for (int i = 3; i >= 0; i--)
    begin
      if ((3'(i) >= from) && f[FLAG_PB_LEN - i])
        opt_from = 3'(i);
    end
  endfunction : opt_from

  // index of the final byte of an optional field
  function automatic logic [7:0] opt_last(input logic [2:0] o);
    opt_last = 8'(SIZE_BYTES - 3'h1);
    if (o == 3'h0)
      opt_last = 8'(PB_LEN_BYTES - 3'h1);
    if (o == 3'h1)
      opt_last = 8'(PB_DELAY_BYTES - 3'h1);
    if (o == 3'h2)
      opt_last = 8'(EXPIRY_BYTES - 3'h1);
  endfunction : opt_last

  // true once sections zero through last are all marked
  function automatic logic all_seen(input logic [255:0] m, input logic [7:0] last);
    all_seen = 1'b1;
    for (int i = 0; i < 256; i++)
    begin
      if ((8'(i) <= last) && !m[i])
        all_seen = 1'b0;
    end
  endfunction : all_seen

  // link handshake and outputs straight from registers
  assign take         = link.valid && link.ready;
  assign b            = link.data;
  assign link.ready   = 1'b1;  // parser never stalls
  assign key_hit      = r.k_ok && (r.service == r.k_svc) && ({r.major, r.minor, r.subnet} == r.k_ext)
                        && (r.span_start == r.k_start);
  assign hdr_valid_o  = r.hdr_valid;
  assign ver_major_o  = r.major;
  assign ver_minor_o  = r.minor;
  assign subnet_o     = r.subnet;
  assign service_o    = r.service;
  assign span_start_o = r.span_start;
  assign span_len_o   = r.span_len;
  assign version_o    = r.version;
  assign new_inst_o   = r.new_inst;
  assign item_valid_o = r.item_valid;
  assign linkage_o    = r.linkage;
  assign item_flags_o = r.flags;
  assign pb_len_o     = r.pb_len;
  assign pb_delay_o   = r.pb_delay;
  assign expiry_o     = r.expiry;
  assign size_o       = r.size;
  assign warn_o       = r.warn;
  assign done_o       = r.done;
  assign complete_o   = r.complete;
  assign error_o      = r.error;
  assign err_code_o   = r.err_code;

  // walker: one byte per beat; an empty field is skipped on the byte that sizes it
  always_comb
  begin
    next_st = st;
    next_r = r;
    next_r.hdr_valid = 1'b0;
    next_r.item_valid = 1'b0;
    next_r.warn = 1'b0;
    next_r.done = 1'b0;
    next_r.error = 1'b0;
    fail = 1'b0;
    code = ERR_NONE;
    desc_end = 1'b0;
    loop_end = 1'b0;
    if (take)
    begin
      next_r.acc = shift_in(r.acc, b);
      next_r.remain = r.remain - 12'h001;
    end
    if (take && link.start)
    begin
      next_r.idx = 4'h0;
      next_st = S_HDR;
      fail = (b != TABLE_ID_VALUE);
      code = ERR_TABLE_ID;
    end
    else if (take)
    begin
      unique case (st)
        S_HDR:
        begin
          next_r.idx = r.idx + 4'h1;
          unique case (r.idx)
            4'h1: next_r.remain = next_r.acc[11:0];
            4'h2:
            begin
              {next_r.major, next_r.minor} = b;
              fail = (b != PROTOCOL_VALUE);
              code = ERR_PROTOCOL;
            end
            4'h3: next_r.subnet = b;
            4'h4:
            begin
              next_r.version = b[5:1];
              fail = !b[0];
              code = ERR_CURRENT;
            end
            4'h5: next_r.secno = b;
            4'h6: next_r.lastno = b;
            4'h8: next_r.service = next_r.acc[15:0];
            4'hC: next_r.span_start = next_r.acc[31:0];
            4'hE: next_r.span_len = next_r.acc[10:0];
            HDR_COUNT_LAST:
            begin
              next_r.items = b;
              next_r.cnt = 8'h00;
              next_r.outer = (b == 8'h00);
              next_st = (b == 8'h00) ? S_DCNT : S_LINK;
              next_r.hdr_valid = 1'b1;
              next_r.new_inst = !key_hit || (r.version != r.k_ver);
              next_r.warn = ((r.span_start % 32'(SECONDS_PER_HOUR)) != 32'h00000000)
                            || (key_hit && (r.span_len != r.k_len))
                            || ((r.span_start == 32'h00000000) && (r.span_len != 11'h000))
                            || (r.span_len > SPAN_LENGTH_MAX) || (r.secno > r.lastno);
              if (next_r.new_inst)
              begin
                next_r.seen = '0;
                next_r.complete = 1'b0;
                next_r.k_ok = 1'b1;
                next_r.k_svc = r.service;
                next_r.k_ext = {r.major, r.minor, r.subnet};
                next_r.k_start = r.span_start;
                next_r.k_len = r.span_len;
                next_r.k_ver = r.version;
              end
            end
            default: ;
          endcase
        end
        S_LINK:
        begin
          next_r.cnt = r.cnt + 8'h01;
          if (r.cnt == 8'(LINKAGE_BYTES - 3'h1))
          begin
            next_r.linkage = next_r.acc[31:0];
            next_r.warn = (next_r.acc[31:0] == 32'h00000000);
            next_st = S_FLAG1;
          end
        end
        S_FLAG1:
        begin
          next_r.flags = b;
          next_st = S_FLAG2;
          if (b[FLAG_MASTER])
          begin
            next_r.warn = r.m_ok && (r.m_svc == r.service) && (r.m_lk != r.linkage);
            next_r.m_ok = 1'b1;
            next_r.m_svc = r.service;
            next_r.m_lk = r.linkage;
          end
        end
        S_FLAG2:
        begin
          next_r.opt = opt_from(r.flags, 3'h0);
          next_r.cnt = 8'h00;
        end
        S_OPT:
        begin
          next_r.cnt = r.cnt + 8'h01;
          if (r.cnt == opt_last(r.opt))
          begin
            unique case (r.opt)
              3'h0: next_r.pb_len = next_r.acc[19:0];
              3'h1: next_r.pb_delay = next_r.acc[19:0];
              3'h2: next_r.expiry = next_r.acc[31:0];
              default: next_r.size = next_r.acc;
            endcase
            next_r.opt = opt_from(r.flags, r.opt + 3'h1);
            next_r.cnt = 8'h00;
          end
        end
        S_NLEN:
        begin
          next_r.dlen = b;
          next_r.outer = 1'b0;
          next_st = (b == 8'h00) ? S_DCNT : S_NAME;
        end
        S_NAME:
        begin
          next_r.dlen = r.dlen - 8'h01;
          if (r.dlen == 8'h01)
            next_st = S_DCNT;
        end
        S_DCNT:
        begin
          next_r.cnt = b;
          loop_end = (b == 8'h00);
          next_st = S_DTAG;
        end
        S_DTAG: next_st = S_DLEN;
        S_DLEN:
        begin
          next_r.dlen = b;
          desc_end = (b == 8'h00);
          next_st = S_DBODY;
        end
        S_DBODY:
        begin
          next_r.dlen = r.dlen - 8'h01;
          desc_end = (r.dlen == 8'h01);
        end
        default: ;
      endcase
      // item ready once its last optional field is in
      if ((st == S_FLAG2) || (st == S_OPT))
      begin
        next_st = (next_r.opt == 3'h4) ? S_NLEN : S_OPT;
        next_r.item_valid = (next_r.opt == 3'h4);
      end
      if (desc_end)
      begin
        next_r.cnt = r.cnt - 8'h01;
        loop_end = (r.cnt == 8'h01);
        next_st = S_DTAG;
      end
      // loop closed: next item, section loop, or wait for the frame end
      if (loop_end)
      begin
        next_r.items = r.items - 8'h01;
        next_r.outer = r.outer || (r.items == 8'h01);
        next_r.cnt = 8'h00;
        next_st = r.outer ? S_TAIL : ((r.items == 8'h01) ? S_DCNT : S_LINK);
      end
    end
    // mandatory field wrong: report once and drop the rest of the frame
    if (fail)
    begin
      next_r.error = 1'b1;
      next_r.err_code = code;
      next_st = S_DROP;
    end
    // end of frame: accept only a walk that ends with the section length
    if (take && link.last)
    begin
      if ((next_st == S_TAIL) && (r.remain == 12'h001))
      begin
        next_r.done = 1'b1;
        next_r.seen[r.secno] = 1'b1;
        next_r.complete = all_seen(next_r.seen, r.lastno);
      end
      else if (next_st != S_DROP)
      begin
        next_r.error = 1'b1;
        next_r.err_code = (next_st != S_TAIL) ? ERR_OVERRUN : ERR_SHORT;
      end
      next_st = S_IDLE;
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= S_IDLE;
      r  <= '0;
    end
    else
    begin
      st <= next_st;
      r  <= next_r;
    end
  end
endmodule : info_section_parser

// ---- logic/info_section_pkg.sv ----
// shared constants and types for the information-section parser and its source
// assumes: one clock domain, bytes delivered one per accepted beat
package info_section_pkg;
  // ****************************************
  // header field constants
  // ****************************************
  localparam logic [7:0]  TABLE_ID_VALUE    = 8'hDF;
  localparam logic [7:0]  PROTOCOL_VALUE    = 8'h10;
  localparam logic [10:0] SPAN_LENGTH_MAX   = 11'h5A0;  // 1440 minutes
  localparam logic [11:0] SECONDS_PER_HOUR  = 12'hE10;  // 3600
  localparam logic [7:0]  HEADER_BYTES      = 8'h0F;    // bytes from offset 2 to item count, inclusive
  localparam logic [3:0]  HDR_COUNT_LAST    = 4'hF;     // header byte index of item count
  // ****************************************
  // item flag positions in the first flag byte
  // ****************************************
  localparam int FLAG_UPDATES  = 7;
  localparam int FLAG_TEXTFRAG = 6;
  localparam int FLAG_SECURITY = 5;
  localparam int FLAG_MASTER   = 4;
  localparam int FLAG_PB_LEN   = 3;
  localparam int FLAG_PB_DELAY = 2;
  localparam int FLAG_EXPIRY   = 1;
  localparam int FLAG_SIZE     = 0;
  // optional field and linkage byte counts
  localparam logic [2:0] PB_LEN_BYTES   = 3'h3;
  localparam logic [2:0] PB_DELAY_BYTES = 3'h3;
  localparam logic [2:0] EXPIRY_BYTES   = 3'h4;
  localparam logic [2:0] SIZE_BYTES     = 3'h5;
  localparam logic [2:0] LINKAGE_BYTES  = 3'h4;
  // ****************************************
  // error codes
  // ****************************************
  typedef enum logic [3:0] {
    ERR_NONE     = 4'h0,
    ERR_TABLE_ID = 4'h1,
    ERR_PROTOCOL = 4'h2,
    ERR_CURRENT  = 4'h3,
    ERR_OVERRUN  = 4'h4,
    ERR_SHORT    = 4'h5
  } err_code_t;
endpackage : info_section_pkg

// ---- logic/section_link_if.sv ----
// byte stream link from the demultiplexer to the parser
// assumes: both ends on the same clock; one section per start..last frame
`timescale 1ns/1ps
interface section_link_if;
  logic       valid;  // byte present
  logic       ready;  // parser takes the byte
  logic [7:0] data;   // section byte
  logic       start;  // first byte of a section
  logic       last;   // final byte of a section
  modport source (output valid, output data, output start, output last, input ready);
  modport sink   (input valid, input data, input start, input last, output ready);
endinterface : section_link_if

// ---- logic/section_source.sv ----
// demultiplexer end: turns user section bytes into link beats
// assumes: user holds byte until taken; the section carries table value and constants
`timescale 1ns/1ps
module section_source
  import info_section_pkg::*;
(
  input  wire logic       clk_i,      // 50 MHz clock
  input  wire logic       resetn_i,   // async reset, active low
  section_link_if.source  link,       // toward the parser
  input  wire logic       put_i,      // user offers a byte
  input  wire logic [7:0] byte_i,     // byte value
  input  wire logic       first_i,    // byte opens a section
  input  wire logic       final_i,    // byte closes a section
  output logic            taken_o     // byte consumed this cycle
);
  logic       vld;
  logic [7:0] dat;
  logic       sof;
  logic       eof;
  logic       next_vld;
  logic [7:0] next_dat;
  logic       next_sof;
  logic       next_eof;

  // one-byte holding stage; sections are framed as produced
  always_comb
  begin
    next_vld = vld;
    next_dat = dat;
    next_sof = sof;
    next_eof = eof;
    if (vld && link.ready)
    begin
      next_vld = 1'b0;
    end
    if (put_i && (!vld || link.ready))
    begin
      next_vld = 1'b1;
      next_dat = byte_i;
      next_sof = first_i;
      next_eof = final_i;
    end
  end

  // register stage
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      vld <= 1'b0;
      dat <= 8'h00;
      sof <= 1'b0;
      eof <= 1'b0;
    end
    else
    begin
      vld <= next_vld;
      dat <= next_dat;
      sof <= next_sof;
      eof <= next_eof;
    end
  end

  assign link.valid = vld;
  assign link.data  = dat;
  assign link.start = sof;
  assign link.last  = eof;
  assign taken_o    = put_i && (!vld || link.ready);
endmodule : section_source

// ---- sim/section_link_props.sv ----
// assertions on the byte link between source and parser
// assumes: placed beside the link; one clock, async low reset
`timescale 1ns/1ps
module section_link_props
  import info_section_pkg::*;
(
  input wire logic       clk_i,    // link clock
  input wire logic       resetn_i, // reset, active low
  input wire logic       valid,    // byte present
  input wire logic       ready,    // byte taken
  input wire logic [7:0] data,     // section byte
  input wire logic       start,    // first byte
  input wire logic       last      // final byte
);
  // ****
  // frame tracking
  // ****
  logic        beat;                    // byte changes hands
  logic        in_frame, next_in_frame; // between start and last
  logic [11:0] cnt, next_cnt;           // index of the next byte
  logic [11:0] len, next_len;           // section length field
  logic [7:0]  prev, next_prev;         // byte before this one
  assign beat = valid && ready;
  // next frame state
  always_comb
  begin
    next_in_frame = beat ? !last : in_frame;
    next_cnt = !beat ? cnt : (start ? 12'h001 : cnt + 12'h001);
    next_prev = beat ? data : prev;
    next_len = len;
    if (beat && cnt == 12'h001)
      next_len[11:8] = data[3:0];
    if (beat && cnt == 12'h002)
      next_len[7:0] = data;
  end
  // register frame state
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      in_frame <= 1'b0;
      cnt <= 12'h000;
      len <= 12'h000;
      prev <= 8'h00;
    end
    else
    begin
      in_frame <= next_in_frame;
      cnt <= next_cnt;
      len <= next_len;
      prev <= next_prev;
    end
  end
  // ****
  // link assertions
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_start_outside: assert property (valid && start |-> !in_frame)
    else $error("start inside frame");
  chk_body_inside: assert property (beat && !start |-> in_frame)
    else $error("byte outside frame");
  chk_frame_length: assert property (beat && last && in_frame |-> cnt + 12'h001 == len + 12'h003)
    else $error("frame length off");
  chk_syntax_bits: assert property (beat && in_frame && cnt == 12'h001 |-> data[7:4] == 4'h7)
    else $error("syntax bits off");
  chk_version_pad: assert property (beat && in_frame && cnt == 12'h005 |-> data[7:6] == 2'b11)
    else $error("version pad off");
  chk_section_order: assert property (beat && in_frame && cnt == 12'h007 |-> prev <= data)
    else $error("section past last");
  chk_span_pad: assert property (beat && in_frame && cnt == 12'h00E |-> data[7:3] == 5'h1F)
    else $error("span pad off");
  chk_span_max: assert property (beat && in_frame && cnt == 12'h00F |-> {prev[2:0], data} <= SPAN_LENGTH_MAX)
    else $error("span too long");
endmodule : section_link_props

// ---- sim/nrt_info_section_parser_test.sv ----
// bench: source and parser joined by the link, random and corner sections
// assumes: package, link interface and checker compiled first
`timescale 1ns/1ps
module nrt_info_section_parser_test;
  import info_section_pkg::*;
  // ****
  // signals and instances
  // ****
  typedef struct packed {logic [31:0] lk; logic [7:0] fl; logic [19:0] pl, pd; logic [31:0] ex; logic [39:0] sz;} item_t;
  logic        clk_i = 1'b0, resetn_i = 1'b0, put_i = 1'b0, first_i = 1'b0, final_i = 1'b0;
  logic [7:0]  byte_i = 8'h00, e_sub, e_pv, s[$];
  logic        taken_o, hdr_valid_o, new_inst_o, item_valid_o, warn_o, done_o, complete_o, error_o;
  logic [3:0]  ver_major_o, ver_minor_o;
  logic [7:0]  subnet_o, item_flags_o;
  logic [15:0] service_o, e_srv;
  logic [31:0] span_start_o, linkage_o, expiry_o, e_start, seed = 32'h6AC7A391;
  logic [10:0] span_len_o, e_len;
  logic [4:0]  version_o, e_ver;
  logic [19:0] pb_len_o, pb_delay_o;
  logic [39:0] size_o;
  err_code_t   err_code_o;
  item_t       eq[$], it;
  int          err_count = 0, n_checks = 0, n_done, n_err, n_warn, n_item;
  section_link_if link ();
  section_source i_section_source (.*);
  info_section_parser i_info_section_parser (.*);
  section_link_props i_section_link_props (.clk_i(clk_i), .resetn_i(resetn_i), .valid(link.valid),
    .ready(link.ready), .data(link.data), .start(link.start), .last(link.last));
  // clock, 20 ns period
  always #10 clk_i = ~clk_i;
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected reason for a discarded section
  function automatic err_code_t exp_code(input logic [7:0] tid, pv, input logic cur);
    if (tid !== TABLE_ID_VALUE)
      return ERR_TABLE_ID;
    if (pv !== PROTOCOL_VALUE)
      return ERR_PROTOCOL;
    return cur ? ERR_NONE : ERR_CURRENT;
  endfunction : exp_code
  task automatic chk(input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // append nb bytes, most significant first
  task automatic put(input logic [63:0] v, input int nb);
    for (int k = nb - 1; k >= 0; k--)
      s.push_back(v[8*k +: 8]);
  endtask : put
  // offer one byte at the falling edge and hold it until taken
  task automatic drive(input logic [7:0] b, input logic f, l);
    int w;
    put_i = 1'b1;
    byte_i = b;
    first_i = f;
    final_i = l;
    for (w = 0; w < 50; w++)
    begin
      #9;
      if (taken_o === 1'b1)
        break;
      @(negedge clk_i);
    end
    chk(w == 50, 0);
    @(negedge clk_i);
  endtask : drive
  // build, send and judge one section with n items
  task automatic send(input logic [7:0] tid, pv, input logic cur, input int n, input logic [31:0] off);
    logic [7:0] b[$];
    item_t      x;
    err_code_t  code;
    code = exp_code(tid, pv, cur);
    s = {};
    e_pv = pv;
    e_sub = 8'(rnd());
    e_srv = 16'(rnd());
    e_ver = 5'(rnd());
    e_start = (rnd() % 32'd20000) * 32'd3600 + off;
    e_len = (off != 0) ? SPAN_LENGTH_MAX : (e_start == 32'h00000000) ? 11'h000 : 11'(rnd() % 1441);
    for (int j = 0; j < n; j++)
    begin
      x.lk = (j == 0) ? 32'hFFFFFFFF : (j == 1) ? 32'h00000001 : rnd() | 32'h1;
      x.fl = (j == 0) ? 8'hFF : 8'(rnd()) & 8'hEF;
      x.pl = 20'(rnd());
      x.pd = 20'(rnd());
      x.ex = rnd();
      x.sz = {8'(rnd()), rnd()};
      put(x.lk, 4);
      put(x.fl, 1);
      put({2'(rnd()), 6'h3F}, 1);
      if (x.fl[FLAG_PB_LEN])
        put({4'hF, x.pl}, 3);
      if (x.fl[FLAG_PB_DELAY])
        put({4'hF, x.pd}, 3);
      if (x.fl[FLAG_EXPIRY])
        put(x.ex, 4);
      if (x.fl[FLAG_SIZE])
        put(x.sz, 5);
      put(1, 1);
      put(rnd(), 1);
      put(0, 1);
      eq.push_back(x);
    end
    put(0, 1);
    b = s;
    s = {};
    put({tid, 4'h7, 12'(b.size() + 14), pv, e_sub, 2'b11, e_ver, cur, 16'h0000}, 8);
    put({e_srv, e_start}, 6);
    put({5'h1F, e_len, 8'(n)}, 3);
    s = {s, b};
    n_done = 0;
    n_err = 0;
    n_warn = 0;
    n_item = 0;
    foreach (s[k])
      drive(s[k], k == 0, k == s.size() - 1);
    put_i = 1'b0;
    for (int w = 0; w < 200 && n_done + n_err == 0; w++)
      @(negedge clk_i);
    chk(n_done, code == ERR_NONE);
    chk(n_err, code != ERR_NONE);
    chk(n_item, code == ERR_NONE ? n : 0);
    chk(n_warn != 0, off != 0);
    chk(code == ERR_NONE ? complete_o : err_code_o, code == ERR_NONE ? 1 : code);
  endtask : send
  // ****
  // output monitor
  // ****
  always @(negedge clk_i)
  begin
    if (hdr_valid_o === 1'b1)
    begin
      chk({ver_major_o, ver_minor_o, subnet_o, service_o}, {e_pv, e_sub, e_srv});
      chk({span_start_o, span_len_o, version_o, new_inst_o}, {e_start, e_len, e_ver, 1'b1});
    end
    if (item_valid_o === 1'b1)
    begin
      n_item++;
      it = eq.size() > 0 ? eq.pop_front() : '0;
      chk({linkage_o, item_flags_o}, {it.lk, it.fl});
      if (it.fl[FLAG_PB_LEN])
        chk(pb_len_o, it.pl);
      if (it.fl[FLAG_PB_DELAY])
        chk(pb_delay_o, it.pd);
      if (it.fl[FLAG_EXPIRY])
        chk(expiry_o, it.ex);
      if (it.fl[FLAG_SIZE])
        chk(size_o, it.sz);
    end
    n_done += (done_o === 1'b1);
    n_err += (error_o === 1'b1);
    n_warn += (warn_o === 1'b1);
  end
  // ****
  // sequence and watchdog
  // ****
  initial
  begin
    repeat (20) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge clk_i);
    for (int r = 0; r < 7; r++)
      send(TABLE_ID_VALUE, PROTOCOL_VALUE, 1'b1, (r + 2) % 4, 0);
    send(8'hDE, PROTOCOL_VALUE, 1'b1, 0, 0);
    send(TABLE_ID_VALUE, 8'h11, 1'b1, 0, 0);
    send(TABLE_ID_VALUE, PROTOCOL_VALUE, 1'b0, 0, 0);
    send(TABLE_ID_VALUE, PROTOCOL_VALUE, 1'b1, 1, 60);
    conclude();
  end
  // cut a hang short well past the few hundred cycles needed
  initial
  begin
    #400000;
    err_count++;
    conclude();
  end
endmodule : nrt_info_section_parser_test
